// [verilog/mlc_top.sv]
/*
  Measurement limit checker with an APB register slave, a shared fail flag,
  two window TTL outputs and a level interrupt.
  Assumes measurement inputs come from logic on clk_sys and APB is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module mlc_top (
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  input  wire logic [mlc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mlc_pkg::DATA_W-1:0]  pwdata,
  output logic      [mlc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        meas_valid,
  input  wire logic [31:0]                 meas_value,
  input  wire logic [1:0]                  meas_kind,
  input  wire logic                        meas_chan,
  input  wire logic                        meas_win,
  output logic                             lim_fail,
  output logic                             ttl_upper,
  output logic                             ttl_lower,
  output logic                             irq
);
  import mlc_pkg::*;

  typedef struct packed {
    logic                    lim_en;
    logic                    win_mode;
    logic                    ttl_en;
    logic                    ttl_pol;
    logic [1:0]              cond;
    logic [1:0]              win_dbm;
    logic [THR_N-1:0][31:0]  thr;
    logic                    fail;
    logic [1:0]              over;
    logic [1:0]              under;
    logic [1:0]              ttl;
    logic [EV_N-1:0]         sts;
    logic [EV_N-1:0]         ien;
    logic                    irq;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } mlc_state_type;

  localparam mlc_state_type ST_RST = '{
    lim_en   : CTRL_RST[CTRL_LIM_EN],
    win_mode : CTRL_RST[CTRL_WIN_MODE],
    ttl_en   : CTRL_RST[CTRL_TTL_EN],
    ttl_pol  : CTRL_RST[CTRL_TTL_POL],
    cond     : CTRL_RST[CTRL_COND_LSB +: 2],
    win_dbm  : CTRL_RST[CTRL_UNIT_LSB +: 2],
    thr      : {DB_LO_RST, DB_HI_RST, DB_LO_RST, DB_HI_RST,
                CH_LO_RST, CH_HI_RST, CH_LO_RST, CH_HI_RST},
    fail     : 1'b0,
    over     : 2'h0,
    under    : 2'h0,
    ttl      : {2{~CTRL_RST[CTRL_TTL_POL]}},
    sts      : '0,
    ien      : '0,
    irq      : 1'b0,
    pready   : 1'b0,
    pslverr  : 1'b0,
    prdata   : 32'h0000_0000
  };

  mlc_state_type s_q;
  mlc_state_type s_d;

  logic [2:0]         sel_hi;
  logic [2:0]         sel_lo;
  logic               cmp_over;
  logic               cmp_under;

  // Picks the threshold pair that the active limit set applies to this result.
  always_comb
  begin
    if (s_q.win_mode)
    begin
      sel_hi = THR_WIN_BASE + {1'b0, meas_win, 1'b0};
    end
    else
    begin
      sel_hi = {1'b0, meas_chan, 1'b0};
    end
    sel_lo = sel_hi | 3'h1;
  end

  mlc_cmp mlc_cmp_i (
    .value  ($signed(meas_value)),
    .thr_hi ($signed(s_q.thr[sel_hi])),
    .thr_lo ($signed(s_q.thr[sel_lo])),
    .over   (cmp_over),
    .under  (cmp_under)
  );

  // Selected failure condition for one window output.
  function automatic logic cond_hit(input logic [1:0] cond,
                                    input logic       over,
                                    input logic       under);
    case (cond)
      COND_OVER:  cond_hit = over;
      COND_UNDER: cond_hit = under;
      default:    cond_hit = over | under;
    endcase
  endfunction

  // Whether a threshold value fits the span of its slot.
  function automatic logic thr_ok(input logic [2:0]         idx,
                                  input logic [1:0]         dbm,
                                  input logic signed [31:0] v);
    if (!idx[2])
    begin
      thr_ok = (v >= CH_MIN) && (v <= CH_MAX);
    end
    else if (dbm[idx[1]])
    begin
      thr_ok = (v >= DBM_MIN) && (v <= DBM_MAX);
    end
    else
    begin
      thr_ok = (v >= DB_MIN) && (v <= DB_MAX);
    end
  endfunction

  always_comb
  begin
    logic            access;
    logic            wr_now;
    logic            judged;
    logic            is_thr;
    logic [2:0]      widx;
    logic [1:0]      new_dbm;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;
    logic            wfail;

    access  = 1'b0;
    wr_now  = 1'b0;
    judged  = 1'b0;
    is_thr  = 1'b0;
    widx    = 3'h0;
    new_dbm = 2'h0;
    ev      = '0;
    clr     = '0;
    wfail   = 1'b0;
    s_d     = s_q;

    is_thr = (paddr >= ADDR_THR_FIRST) && (paddr <= ADDR_THR_LAST);
    widx   = 3'(paddr[4:2] - ADDR_THR_FIRST[4:2]);

    // One wait state: pready rises in the second access cycle.
    access      = psel && penable && !s_q.pready;
    s_d.pready  = access;
    // Error and read data stand only in the cycle in which pready does.
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (access)
    begin
      if (pwrite)
      begin
        if (is_thr)
        begin
          // Out-of-span values are refused and the slot keeps its value.
          s_d.pslverr = !thr_ok(widx, s_q.win_dbm, $signed(pwdata));
        end
        else if ((paddr != ADDR_CTRL) && (paddr != ADDR_IRQ_CLR)
                 && (paddr != ADDR_IRQ_EN))
        begin
          s_d.pslverr = 1'b1;
        end
      end
      else
      begin
        case (paddr)
          ADDR_CTRL:
          begin
            s_d.prdata[CTRL_LIM_EN]          = s_q.lim_en;
            s_d.prdata[CTRL_WIN_MODE]        = s_q.win_mode;
            s_d.prdata[CTRL_TTL_EN]          = s_q.ttl_en;
            s_d.prdata[CTRL_TTL_POL]         = s_q.ttl_pol;
            s_d.prdata[CTRL_COND_LSB +: 2]   = s_q.cond;
            s_d.prdata[CTRL_UNIT_LSB +: 2]   = s_q.win_dbm;
          end
          ADDR_STATUS:
          begin
            s_d.prdata[ST_FAIL]              = s_q.fail;
            s_d.prdata[ST_OVER_LSB +: 2]     = s_q.over;
            s_d.prdata[ST_UNDER_LSB +: 2]    = s_q.under;
          end
          ADDR_IRQ_STS: s_d.prdata[EV_N-1:0] = s_q.sts;
          ADDR_IRQ_EN:  s_d.prdata[EV_N-1:0] = s_q.ien;
          ADDR_IRQ_CLR: s_d.prdata           = 32'h0000_0000;
          default:
          begin
            if (is_thr)
            begin
              s_d.prdata = s_q.thr[widx];
            end
            else
            begin
              s_d.pslverr = 1'b1;
            end
          end
        endcase
      end
    end

    // A write lands only at the edge where pready is seen high.
    wr_now = psel && penable && pwrite && s_q.pready;
    if (wr_now && s_q.pslverr && is_thr)
    begin
      ev[EV_REJECT] = 1'b1;
    end
    if (wr_now && !s_q.pslverr)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          s_d.lim_en   = pwdata[CTRL_LIM_EN];
          s_d.win_mode = pwdata[CTRL_WIN_MODE];
          s_d.ttl_en   = pwdata[CTRL_TTL_EN];
          s_d.ttl_pol  = pwdata[CTRL_TTL_POL];
          s_d.cond     = pwdata[CTRL_COND_LSB +: 2];
          new_dbm      = pwdata[CTRL_UNIT_LSB +: 2];
          s_d.win_dbm  = new_dbm;
          for (int w = 0; w < 2; w++)
          begin
            // A change of units reloads that window's defaults.
            if (new_dbm[w] != s_q.win_dbm[w])
            begin
              s_d.thr[THR_WIN_BASE + 3'(2 * w)] = new_dbm[w] ? DBM_HI_RST : DB_HI_RST;
              s_d.thr[THR_WIN_BASE + 3'(2 * w + 1)] = new_dbm[w] ? DBM_LO_RST : DB_LO_RST;
            end
          end
          // Results of the old set mean nothing once the set changes.
          if (pwdata[CTRL_WIN_MODE] != s_q.win_mode)
          begin
            s_d.fail  = 1'b0;
            s_d.over  = 2'h0;
            s_d.under = 2'h0;
          end
        end
        ADDR_IRQ_CLR: clr = pwdata[EV_N-1:0];
        ADDR_IRQ_EN:  s_d.ien = pwdata[EV_N-1:0];
        default:
        begin
          if (is_thr)
          begin
            s_d.thr[widx] = pwdata;
          end
        end
      endcase
    end

    // Ratio and difference results pass untouched in channel mode.
    judged = meas_valid && s_q.lim_en
             && (s_q.win_mode || (meas_kind == KIND_POWER));
    if (judged)
    begin
      s_d.fail = cmp_over || cmp_under;
      ev[EV_FAIL] = cmp_over || cmp_under;
      if (s_q.win_mode)
      begin
        s_d.over[meas_win]  = cmp_over;
        s_d.under[meas_win] = cmp_under;
        ev[EV_WIN0 + 32'(meas_win)] = cmp_over || cmp_under;
      end
    end

    if (!s_d.lim_en)
    begin
      s_d.fail  = 1'b0;
      s_d.over  = 2'h0;
      s_d.under = 2'h0;
    end

    for (int w = 0; w < 2; w++)
    begin
      wfail = s_d.lim_en && s_d.win_mode && s_d.ttl_en
              && cond_hit(s_d.cond, s_d.over[w], s_d.under[w]);
      s_d.ttl[w] = s_d.ttl_pol ? wfail : !wfail;
    end

    // A new event outweighs a clear in the same cycle.
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.irq = |(s_d.sts & s_d.ien);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= ST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign lim_fail  = s_q.fail;
  assign ttl_upper = s_q.ttl[0];
  assign ttl_lower = s_q.ttl[1];
  assign irq       = s_q.irq;

endmodule

`default_nettype wire

// [pkg/mlc_pkg.sv]
/*
  Constants shared by the measurement limit checker: register byte addresses,
  control field positions, event bits, measurement kinds and threshold spans.
  Assumes thresholds and results are signed 32-bit values in 0.01 dB steps.
*/
package mlc_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STS   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0]  ADDR_THR_FIRST = 8'h14;
  localparam logic [7:0]  ADDR_THR_LAST  = 8'h30;

  localparam int          THR_N          = 8;
  localparam logic [2:0]  THR_WIN_BASE   = 3'h4;

  localparam int          CTRL_LIM_EN    = 0;
  localparam int          CTRL_WIN_MODE  = 1;
  localparam int          CTRL_TTL_EN    = 2;
  localparam int          CTRL_TTL_POL   = 3;
  localparam int          CTRL_COND_LSB  = 4;
  localparam int          CTRL_UNIT_LSB  = 6;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0028;

  localparam int          ST_FAIL        = 0;
  localparam int          ST_OVER_LSB    = 1;
  localparam int          ST_UNDER_LSB   = 3;

  localparam int          EV_N           = 4;
  localparam int          EV_FAIL        = 0;
  localparam int          EV_WIN0        = 1;
  localparam int          EV_WIN1        = 2;
  localparam int          EV_REJECT      = 3;

  localparam logic [1:0]  KIND_POWER     = 2'h0;
  localparam logic [1:0]  KIND_RATIO     = 2'h1;
  localparam logic [1:0]  KIND_DIFF      = 2'h2;

  typedef enum logic [1:0] {
    COND_OVER,
    COND_UNDER,
    COND_EITHER
  } mlc_cond_type;

  localparam logic signed [31:0] CH_MIN     = -32'sh0000_3A98;
  localparam logic signed [31:0] CH_MAX     =  32'sh0000_59D8;
  localparam logic signed [31:0] CH_HI_RST  =  32'sh0000_2328;
  localparam logic signed [31:0] CH_LO_RST  = -32'sh0000_2328;
  localparam logic signed [31:0] DB_MIN     = -32'sh0000_4650;
  localparam logic signed [31:0] DB_MAX     =  32'sh0000_4E20;
  localparam logic signed [31:0] DB_HI_RST  =  32'sh0000_1770;
  localparam logic signed [31:0] DB_LO_RST  = -32'sh0000_2EE0;
  localparam logic signed [31:0] DBM_MIN    = -32'sh0000_3A98;
  localparam logic signed [31:0] DBM_MAX    =  32'sh0000_59D8;
  localparam logic signed [31:0] DBM_HI_RST =  32'sh0000_2328;
  localparam logic signed [31:0] DBM_LO_RST = -32'sh0000_2328;

endpackage

// [verilog/mlc_cmp.sv]
/*
  Combinational comparison of one result against an upper and a lower threshold.
  Assumes all three values are signed and on the same scale.
*/
`timescale 1ns/1ps
`default_nettype none

module mlc_cmp (
  input  wire logic signed [31:0] value,
  input  wire logic signed [31:0] thr_hi,
  input  wire logic signed [31:0] thr_lo,
  output logic                    over,
  output logic                    under
);

  // Equal to a threshold counts as inside the limits.
  assign over  = value > thr_hi;
  assign under = value < thr_lo;

endmodule

`default_nettype wire

// [verification/mlc_assertions.sv]
/*
  Port checker for mlc_top: APB timing and when the limit outputs may move.
  Assumes one clock domain and a master that keeps the APB protocol.
*/
`timescale 1ns/1ps
`default_nettype none
module mlc_assertions (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        meas_valid,
  input wire logic        lim_fail,
  input wire logic        ttl_upper,
  input wire logic        ttl_lower,
  input wire logic        irq
);
  logic wr_done;
  assign wr_done = psel & pready & pwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  pready_pulse_a:
    assert property (pready |=> !pready) else $error("pready held too long");
  apb_wait_a:
    assert property (psel && !penable |-> ##2 pready) else $error("no answer in time");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  wr_data_a:
    assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  fail_hold_a:
    assert property (!meas_valid && !wr_done |=> $stable(lim_fail))
    else $error("fail flag moved without cause");
  ttl_hold_a:
    assert property (!meas_valid && !wr_done |=> $stable(ttl_upper) && $stable(ttl_lower))
    else $error("ttl pin moved without cause");
  fail_cause_a:
    assert property ($rose(lim_fail) |-> $past(meas_valid)) else $error("fail with no result");
  irq_cause_a:
    assert property ($rose(irq) |-> $past(meas_valid) || $past(wr_done) || $past(wr_done, 2))
    else $error("irq with no event");
endmodule
`default_nettype wire

// [verification/mlc_ttl_probe.sv]
/*
  Test set that reads the two limit pins and decodes fail or pass.
  Assumes it is told which level the block was set to use for a fail.
*/
`timescale 1ns/1ps
`default_nettype none
module mlc_ttl_probe (
  input  wire logic ttl_upper,
  input  wire logic ttl_lower,
  input  wire logic fail_high,
  output logic      up_fail,
  output logic      lo_fail
);
  // The pins carry no framing, so the level alone is the verdict.
  assign up_fail = (ttl_upper == fail_high);
  assign lo_fail = (ttl_lower == fail_high);
endmodule
`default_nettype wire

// [verification/mlc_top_tb_top.sv]
/*
  Self-checking bench for mlc_top with the pin probe and the port checker.
  Assumes the register map and defaults of mlc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module mlc_top_tb_top;
  import mlc_pkg::*;
  logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, meas_value = 32'h0000_0000, prdata, rd;
  logic [1:0]  meas_kind = 2'h0;
  logic        meas_valid = 0, meas_chan = 0, meas_win = 0, pol_high = 1;
  logic        pready, pslverr, lim_fail, ttl_upper, ttl_lower, irq, up_fail, lo_fail, er;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  // Rows: value, kind, window, then fail, upper pin fail, lower pin fail.
  logic [37:0] rows [5] = '{{32'h0000_1770, 2'h0, 1'b0, 3'b000},
    {32'h0000_1771, 2'h0, 1'b0, 3'b110}, {32'hFFFF_D11F, 2'h1, 1'b1, 3'b111},
    {32'hFFFF_D120, 2'h2, 1'b1, 3'b010}, {32'h0000_0000, 2'h0, 1'b0, 3'b000}};
  logic [40:0] spans [7] = '{{ADDR_THR_FIRST, 32'h0000_59D9, 1'b1},
    {ADDR_THR_FIRST, 32'h0000_59D8, 1'b0}, {8'h24, 32'h0000_4E21, 1'b1},
    {8'h24, 32'h0000_4E20, 1'b0}, {8'h28, 32'hFFFF_B9AF, 1'b1},
    {8'h40, 32'h0000_0000, 1'b1}, {ADDR_STATUS, 32'h0000_0000, 1'b1}};
  logic [39:0] defs [5] = '{{ADDR_CTRL, 32'h0000_0028}, {8'h14, 32'h0000_2328},
    {8'h18, 32'hFFFF_DCD8}, {8'h24, 32'h0000_1770}, {8'h28, 32'hFFFF_D120}};

  always #4 clk_sys = ~clk_sys;

  mlc_top mlc_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_kind(meas_kind), .meas_chan(meas_chan), .meas_win(meas_win),
    .lim_fail(lim_fail), .ttl_upper(ttl_upper), .ttl_lower(ttl_lower), .irq(irq));
  mlc_ttl_probe mlc_ttl_probe_i (.ttl_upper(ttl_upper), .ttl_lower(ttl_lower),
    .fail_high(pol_high), .up_fail(up_fail), .lo_fail(lo_fail));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits as long as the slave needs; only the bench timeout ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic judge(input logic [31:0] v, input logic [1:0] k, input logic c,
                       input logic w, input logic [2:0] e);
    @(posedge clk_sys);
    meas_valid <= 1; meas_value <= v; meas_kind <= k; meas_chan <= c; meas_win <= w;
    @(posedge clk_sys);
    meas_valid <= 0;
    #1;
    chk({29'h0, lim_fail, up_fail, lo_fail}, {29'h0, e});
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The ceiling is over thirty times the length of the whole sequence.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop;
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1;
    apb(1, ADDR_CTRL, 32'h0000_002F);
    foreach (rows[i])
      judge(rows[i][37:6], rows[i][5:4], 1'b0, rows[i][3], rows[i][2:0]);
    for (int c = 0; c < 3; c++)
    begin
      apb(1, ADDR_CTRL, 32'(c << 4) | 32'h0000_000F);
      judge(32'h0000_1B58, KIND_POWER, 0, 0, {1'b1, c != 1, 1'b0});
      judge(32'hFFFF_CD38, KIND_POWER, 0, 0, {1'b1, c != 0, 1'b0});
    end
    apb(1, ADDR_CTRL, 32'h0000_0027);
    pol_high <= 0;
    judge(32'h0000_1B58, KIND_POWER, 0, 0, 3'b110);
    chk(ttl_upper, 0);
    pol_high <= 1;
    apb(1, ADDR_CTRL, 32'h0000_002B);
    judge(32'h0000_1B58, KIND_POWER, 0, 0, 3'b100);
    apb(1, ADDR_CTRL, 32'h0000_002F);
    judge(32'h0000_1B58, KIND_POWER, 0, 0, 3'b110);
    apb(1, ADDR_CTRL, 32'h0000_002E);
    judge(32'h0000_1B58, KIND_POWER, 0, 0, 3'b000);
    apb(1, ADDR_CTRL, 32'h0000_002F);
    judge(32'h0000_1771, KIND_POWER, 0, 0, 3'b110);
    // Fail-high polarity kept so that the probe reads the pass level as pass.
    apb(1, ADDR_CTRL, 32'h0000_0029);
    judge(32'h0001_869F, KIND_RATIO, 0, 0, 3'b000);
    judge(32'h0000_1B58, KIND_POWER, 0, 0, 3'b000);
    judge(32'h0000_2329, KIND_POWER, 1, 0, 3'b100);
    judge(32'h0000_0000, KIND_DIFF, 1, 0, 3'b100);
    apb(1, ADDR_IRQ_EN, 32'h0000_0008);
    foreach (spans[i])
    begin
      apb(1, spans[i][40:33], spans[i][32:1]);
      chk(er, spans[i][0]);
    end
    chk(irq, 1);
    apb(1, ADDR_IRQ_CLR, 32'h0000_0008);
    apb(0, ADDR_IRQ_STS, 32'h0000_0000);
    chk(rd & 32'h0000_0008, 0);
    chk(irq, 0);
    apb(1, ADDR_IRQ_EN, 32'h0000_0000);
    apb(1, ADDR_THR_FIRST, 32'h0000_59D9);
    apb(0, ADDR_IRQ_STS, 32'h0000_0000);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    chk(irq, 0);
    @(posedge clk_sys);
    arst_n <= 0;
    @(posedge clk_sys);
    #1;
    chk(lim_fail, 0);
    @(posedge clk_sys);
    arst_n <= 1;
    foreach (defs[i])
    begin
      apb(0, defs[i][39:32], 32'h0000_0000);
      chk(rd, defs[i][31:0]);
    end
    report_and_stop;
  end
endmodule

bind mlc_top mlc_assertions mlc_assertions_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .meas_valid(meas_valid), .lim_fail(lim_fail),
  .ttl_upper(ttl_upper), .ttl_lower(ttl_lower), .irq(irq));
`default_nettype wire
